//--- rtl/meas_cmd_pkg.sv
// Constants for the measurement and test command sequencer.
// Assumes a 100 MHz system clock and a serial command decoder on the same clock.
package meas_cmd_pkg;

    // Command codes as delivered by the serial decoder
    localparam logic [7:0] CMD_AM_TOGGLE   = 8'hD2;
    localparam logic [7:0] CMD_MEAS_AMP    = 8'hD3;
    localparam logic [7:0] CMD_GAIN_RESET  = 8'hD5;
    localparam logic [7:0] CMD_REG_ADJUST  = 8'hD6;
    localparam logic [7:0] CMD_MEAS_PHASE  = 8'hD9;
    localparam logic [7:0] CMD_CLEAR_RSSI  = 8'hDA;
    localparam logic [7:0] CMD_TRANSPARENT = 8'hDC;
    localparam logic [7:0] CMD_CAP_CAL     = 8'hDD;
    localparam logic [7:0] CMD_CAP_MEAS    = 8'hDE;
    localparam logic [7:0] CMD_MEAS_SUPPLY = 8'hDF;
    localparam logic [7:0] CMD_TEST_ACCESS = 8'hFC;

    // Test register space
    localparam logic [5:0] OBS_SEL_ADDR    = 6'h01;
    localparam logic [7:0] OBS_SEL_RESET   = 8'h40;
    localparam int         OBS_FIELD_LSB   = 0;
    localparam int         OBS_FIELD_W     = 4;

    // Converter source encoding
    localparam logic [1:0] SRC_AMPLITUDE   = 2'h0;
    localparam logic [1:0] SRC_PHASE       = 2'h1;
    localparam logic [1:0] SRC_SUPPLY      = 2'h2;

    // Timing
    localparam int CLK_MHZ        = 100;
    localparam int ADC_TIME_US    = 25;
    localparam int REG_ADJ_MS     = 5;
    localparam int CAP_CAL_MS     = 3;
    localparam int CAP_MEAS_US    = 250;
    localparam int ADC_CYCLES     = ADC_TIME_US * CLK_MHZ;
    localparam int REG_ADJ_CYCLES = REG_ADJ_MS * 1000 * CLK_MHZ;
    localparam int CAP_CAL_CYCLES = CAP_CAL_MS * 1000 * CLK_MHZ;
    localparam int CAP_MEAS_CYC   = CAP_MEAS_US * CLK_MHZ;
    localparam int CNT_W          = 20;

endpackage : meas_cmd_pkg

//--- rtl/meas_cmd_seq.sv
// Measurement and test command sequencer.
// Assumes commands and register accesses arrive as one-cycle strobes from the
// serial decoder on clk_sys; analog blocks answer with done strobes on clk_sys.
`timescale 1ns/10ps
`default_nettype none

module meas_cmd_seq
    import meas_cmd_pkg::*;
#(
    parameter int ADJ_CYC  = REG_ADJ_CYCLES,
    parameter int CAL_CYC  = CAP_CAL_CYCLES,
    parameter int CMEAS_CYC = CAP_MEAS_CYC,
    parameter int MCAL_W   = 4
) (
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    input  wire logic              cmd_valid,
    input  wire logic [7:0]        cmd_code,
    input  wire logic              serial_frame_select,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [5:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              tx_en_cfg,
    input  wire logic              rx_en_cfg,
    input  wire logic              ext_reg_select,
    input  wire logic [2:0]        supply_select,
    input  wire logic [MCAL_W-1:0] manual_cal,
    input  wire logic              ready_mode,
    input  wire logic              new_reception,
    input  wire logic              adc_done,
    input  wire logic [7:0]        adc_data,
    input  wire logic              reg_adj_done,
    input  wire logic              cap_done,
    input  wire logic [7:0]        obs_digital,
    output logic                   tx_enable_r,
    output logic                   rx_enable_r,
    output logic                   am_modulated_r,
    output logic                   amp_det_en_r,
    output logic                   phase_det_en_r,
    output logic                   adc_start_r,
    output logic                   adc_abs_mode_r,
    output logic [1:0]             adc_source_r,
    output logic [2:0]             adc_supply_sel_r,
    output logic [7:0]             converter_result_r,
    output logic                   gain_reset_r,
    output logic                   rssi_clear_r,
    output logic                   reg_adj_start_r,
    output logic                   cap_cal_start_r,
    output logic                   cap_meas_start_r,
    output logic                   cap_cal_irq_r,
    output logic                   transparent_r,
    output logic                   test_space_r,
    output logic [7:0]             test_rdata_r,
    output logic [7:0]             obs_select_r,
    output logic                   observation_pin_a_r,
    output logic                   observation_pin_b_r,
    output logic                   busy_r
);

    generate
        if (ADJ_CYC < 1 || ADJ_CYC >= (1 << CNT_W) || CAL_CYC < 1 ||
            CAL_CYC >= (1 << CNT_W) || CMEAS_CYC < 1 || CMEAS_CYC >= (1 << CNT_W))
            $error("meas_cmd_seq: cycle count out of counter range");
        if (MCAL_W < 1 || MCAL_W > 8)
            $error("meas_cmd_seq: manual calibration width unsupported");
    endgenerate

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADC,
        ST_REG_ADJ,
        ST_CAP_CAL,
        ST_CAP_MEAS
    } state_e;

    typedef struct packed {
        state_e            state;
        logic [CNT_W-1:0]  cnt;
        logic              fs_meta;
        logic              fs_sync;
        logic              fs_prev;
        logic              transparent_armed;
        logic              tx_en;
        logic              rx_en;
        logic              am_mod;
        logic              amp_en;
        logic              ph_en;
        logic              adc_start;
        logic              adc_abs;
        logic [1:0]        adc_src;
        logic [2:0]        sup_sel;
        logic [7:0]        result;
        logic              gain_rst;
        logic              rssi_clr;
        logic              adj_start;
        logic              cal_start;
        logic              meas_start;
        logic              cal_irq;
        logic              transparent;
        logic              test_space;
        logic [7:0]        rdata;
        logic [7:0]        obs_sel;
        logic              pin_a;
        logic              pin_b;
        logic              busy;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    // Compares elapsed cycles of a running command against its limit
    function automatic logic expired(input logic [CNT_W-1:0] c, input int lim);
        expired = (c >= CNT_W'(lim - 1));
    endfunction : expired

    // Starts a converter run; transmitter forced on for the amplitude and phase measurements
    function automatic state_s start_adc(input state_s s, input logic [1:0] src,
                                         input logic abs_mode);
        state_s t;
        t = s;
        t.state = ST_ADC;
        t.cnt = '0;
        t.adc_start = 1'b1;
        t.adc_src = src;
        t.adc_abs = abs_mode;
        t.tx_en = 1'b1;
        start_adc = t;
    endfunction : start_adc

    logic fs_rise;
    logic fs_fall;
    logic cmd_go;
    logic [3:0] obs_field;

    assign fs_rise   = st_r.fs_sync & ~st_r.fs_prev;
    assign fs_fall   = ~st_r.fs_sync & st_r.fs_prev;
    assign cmd_go    = cmd_valid & (st_r.state == ST_IDLE);
    assign obs_field = st_r.obs_sel[OBS_FIELD_LSB +: OBS_FIELD_W];

    always_comb begin
        st_nxt = st_r;
        st_nxt.fs_meta    = serial_frame_select;
        st_nxt.fs_sync    = st_r.fs_meta;
        st_nxt.fs_prev    = st_r.fs_sync;
        st_nxt.adc_start  = 1'b0;
        st_nxt.gain_rst   = 1'b0;
        st_nxt.adj_start  = 1'b0;
        st_nxt.cal_start  = 1'b0;
        st_nxt.meas_start = 1'b0;
        st_nxt.cal_irq    = 1'b0;
        st_nxt.rssi_clr   = new_reception;
        st_nxt.cnt        = st_r.cnt + CNT_W'(1);

        // Enables follow the configuration only while idle; a running command forces or holds them
        if (st_r.state == ST_IDLE) begin
            st_nxt.tx_en = tx_en_cfg;
            st_nxt.rx_en = rx_en_cfg;
        end

        // Frame end starts transparent mode, next frame start ends it
        if (fs_rise) begin
            st_nxt.test_space = 1'b0;
            if (st_r.transparent_armed) begin
                st_nxt.transparent = 1'b1;
                st_nxt.transparent_armed = 1'b0;
            end
        end
        if (fs_fall) begin
            st_nxt.transparent = 1'b0;
        end

        // Test space accesses; only the observation register is populated
        if (st_r.test_space && reg_wr && reg_addr == OBS_SEL_ADDR) begin
            st_nxt.obs_sel = reg_wdata;
        end
        if (st_r.test_space && reg_rd) begin
            st_nxt.rdata = (reg_addr == OBS_SEL_ADDR) ? st_r.obs_sel : 8'h00;
        end

        // Observation routing; analog codes leave the digital pins low
        st_nxt.pin_a = 1'b0;
        st_nxt.pin_b = 1'b0;
        case (obs_field)
            4'h1:    st_nxt.pin_b = obs_digital[0];
            4'h2:    st_nxt.pin_b = obs_digital[1];
            4'h5:    st_nxt.pin_b = obs_digital[2];
            4'h6:    st_nxt.pin_b = obs_digital[3];
            4'h7:    st_nxt.pin_b = obs_digital[4];
            4'hB: begin
                st_nxt.pin_a = obs_digital[5];
                st_nxt.pin_b = obs_digital[6];
            end
            4'hC: begin
                st_nxt.pin_a = obs_digital[7];
                st_nxt.pin_b = obs_digital[6];
            end
            default: begin
                st_nxt.pin_a = 1'b0;
                st_nxt.pin_b = 1'b0;
            end
        endcase

        case (st_r.state)
            ST_IDLE: begin
                if (cmd_go) begin
                    case (cmd_code)
                        CMD_AM_TOGGLE:   st_nxt.am_mod = ~st_r.am_mod;
                        CMD_MEAS_AMP: begin
                            st_nxt = start_adc(st_nxt, SRC_AMPLITUDE, 1'b1);
                            st_nxt.amp_en = 1'b1;
                        end
                        CMD_MEAS_PHASE: begin
                            st_nxt = start_adc(st_nxt, SRC_PHASE, 1'b0);
                            st_nxt.ph_en = 1'b1;
                        end
                        CMD_MEAS_SUPPLY: begin
                            st_nxt = start_adc(st_nxt, SRC_SUPPLY, 1'b1);
                            st_nxt.tx_en = tx_en_cfg;
                            st_nxt.sup_sel = supply_select;
                        end
                        CMD_GAIN_RESET:  st_nxt.gain_rst = 1'b1;
                        CMD_CLEAR_RSSI:  st_nxt.rssi_clr = 1'b1;
                        CMD_REG_ADJUST: begin
                            // Refused quietly when the regulator is set externally
                            if (!ext_reg_select) begin
                                st_nxt.state = ST_REG_ADJ;
                                st_nxt.cnt = '0;
                                st_nxt.adj_start = 1'b1;
                                st_nxt.tx_en = 1'b1;
                                st_nxt.rx_en = 1'b1;
                            end
                        end
                        CMD_TRANSPARENT: st_nxt.transparent_armed = 1'b1;
                        CMD_CAP_CAL: begin
                            if (manual_cal == '0) begin
                                st_nxt.state = ST_CAP_CAL;
                                st_nxt.cnt = '0;
                                st_nxt.cal_start = 1'b1;
                            end
                        end
                        CMD_CAP_MEAS: begin
                            st_nxt.state = ST_CAP_MEAS;
                            st_nxt.cnt = '0;
                            st_nxt.meas_start = 1'b1;
                        end
                        CMD_TEST_ACCESS: st_nxt.test_space = 1'b1;
                        default: st_nxt.state = ST_IDLE;
                    endcase
                end
            end
            ST_ADC: begin
                // Timeout bounds the command even if the converter never answers
                if (adc_done || expired(st_r.cnt, ADC_CYCLES)) begin
                    if (adc_done) begin
                        st_nxt.result = adc_data;
                    end
                    st_nxt.state = ST_IDLE;
                    st_nxt.amp_en = 1'b0;
                    st_nxt.ph_en = 1'b0;
                end
            end
            ST_REG_ADJ: begin
                if (reg_adj_done || expired(st_r.cnt, ADJ_CYC)) begin
                    st_nxt.state = ST_IDLE;
                    st_nxt.tx_en = tx_en_cfg;
                    st_nxt.rx_en = rx_en_cfg;
                end
            end
            ST_CAP_CAL: begin
                if (cap_done || expired(st_r.cnt, CAL_CYC)) begin
                    st_nxt.state = ST_IDLE;
                    st_nxt.cal_irq = ready_mode;
                end
            end
            ST_CAP_MEAS: begin
                if (cap_done || expired(st_r.cnt, CMEAS_CYC)) begin
                    st_nxt.state = ST_IDLE;
                end
            end
            default: st_nxt.state = ST_IDLE;
        endcase

        // Busy kept in its own flop so the output carries no state decode
        st_nxt.busy = (st_nxt.state != ST_IDLE);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
            st_r.state <= ST_IDLE;
            st_r.fs_meta <= 1'b1;
            st_r.fs_sync <= 1'b1;
            st_r.fs_prev <= 1'b1;
            st_r.obs_sel <= OBS_SEL_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tx_enable_r         = st_r.tx_en;
    assign rx_enable_r         = st_r.rx_en;
    assign am_modulated_r      = st_r.am_mod;
    assign amp_det_en_r        = st_r.amp_en;
    assign phase_det_en_r      = st_r.ph_en;
    assign adc_start_r         = st_r.adc_start;
    assign adc_abs_mode_r      = st_r.adc_abs;
    assign adc_source_r        = st_r.adc_src;
    assign adc_supply_sel_r    = st_r.sup_sel;
    assign converter_result_r  = st_r.result;
    assign gain_reset_r        = st_r.gain_rst;
    assign rssi_clear_r        = st_r.rssi_clr;
    assign reg_adj_start_r     = st_r.adj_start;
    assign cap_cal_start_r     = st_r.cal_start;
    assign cap_meas_start_r    = st_r.meas_start;
    assign cap_cal_irq_r       = st_r.cal_irq;
    assign transparent_r       = st_r.transparent;
    assign test_space_r        = st_r.test_space;
    assign test_rdata_r        = st_r.rdata;
    assign obs_select_r        = st_r.obs_sel;
    assign observation_pin_a_r = st_r.pin_a;
    assign observation_pin_b_r = st_r.pin_b;
    assign busy_r              = st_r.busy;

endmodule : meas_cmd_seq

`default_nettype wire

//--- sim/analog_resp.sv
// Analog side responder for the command sequencer.
// Assumes one-cycle start strobes from the sequencer on clk_sys.
`timescale 1ns/10ps
`default_nettype none
module analog_resp (
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic       adc_start_r,
    input  wire logic [1:0] adc_source_r,
    input  wire logic       reg_adj_start_r,
    input  wire logic       cap_cal_start_r,
    input  wire logic       cap_meas_start_r,
    input  wire logic       mute,
    input  wire logic [7:0] dly,
    output logic            adc_done,
    output logic [7:0]      adc_data,
    output logic            reg_adj_done,
    output logic            cap_done
);
    logic [7:0] cnt;
    logic [7:0] val;
    logic [2:0] kind;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            {cnt, val, kind, adc_done, reg_adj_done, cap_done} <= '0;
            adc_data <= 8'hA5;
        end else begin
            {adc_done, reg_adj_done, cap_done} <= 3'h0;
            // Toggles outside a strobe so a stale value never passes
            adc_data <= ~adc_data;
            if (adc_start_r || reg_adj_start_r || cap_cal_start_r || cap_meas_start_r) begin
                cnt  <= dly;
                kind <= {adc_start_r, cap_cal_start_r | cap_meas_start_r, reg_adj_start_r};
                val  <= 8'h30 + {2'h0, adc_source_r, 4'h0};
            end else if (cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
                // Mute stands for a converter that never answers
                if (cnt == 8'h01 && !mute) begin
                    {adc_done, cap_done, reg_adj_done} <= kind;
                    adc_data <= val;
                end
            end
        end
    end
endmodule : analog_resp
`default_nettype wire

//--- sim/meas_cmd_chk.sv
// Checker for the command sequencer, bound to its ports.
// Assumes one clock clk_sys and active-low asynchronous reset nrst.
`timescale 1ns/10ps
`default_nettype none
module meas_cmd_chk
    import meas_cmd_pkg::*;
#(
    parameter int MCAL_W = 4
) (
    input wire logic              clk_sys,
    input wire logic              nrst,
    input wire logic              cmd_valid,
    input wire logic [7:0]        cmd_code,
    input wire logic              busy_r,
    input wire logic              am_modulated_r,
    input wire logic              adc_start_r,
    input wire logic              adc_abs_mode_r,
    input wire logic [1:0]        adc_source_r,
    input wire logic              amp_det_en_r,
    input wire logic              phase_det_en_r,
    input wire logic              tx_enable_r,
    input wire logic              reg_adj_start_r,
    input wire logic              ext_reg_select,
    input wire logic              cap_cal_start_r,
    input wire logic [MCAL_W-1:0] manual_cal,
    input wire logic              rssi_clear_r,
    input wire logic              new_reception,
    input wire logic              adc_done,
    input wire logic [7:0]        adc_data,
    input wire logic [7:0]        converter_result_r
);
    // Converter timeout plus a little slack
    localparam int ADC_LIM = 2510;
    logic go;
    assign go = cmd_valid && !busy_r;
    // The converter bound is too long for a delay range, so it is counted
    logic        amp_run;
    logic [11:0] amp_cnt;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            amp_run <= 1'b0;
            amp_cnt <= 12'h000;
        end else if (go && cmd_code == CMD_MEAS_AMP) begin
            amp_run <= 1'b1;
            amp_cnt <= 12'h000;
        end else if (!busy_r) begin
            amp_run <= 1'b0;
        end else if (amp_cnt != 12'hFFF) begin
            amp_cnt <= amp_cnt + 12'h001;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    sequence s_amp_go;
        go && cmd_code == CMD_MEAS_AMP;
    endsequence
    sequence s_launch;
        adc_start_r && tx_enable_r ##1 !adc_start_r;
    endsequence
    chk_am_toggle: assert property (go && cmd_code == CMD_AM_TOGGLE
        |=> am_modulated_r != $past(am_modulated_r)) else $error("AM state kept");
    chk_amp_launch: assert property (s_amp_go |=> amp_det_en_r && adc_abs_mode_r
        && adc_source_r == SRC_AMPLITUDE ##0 s_launch) else $error("Bad amp launch");
    chk_amp_bound: assert property (amp_run |-> amp_cnt <= 12'(ADC_LIM))
        else $error("Amp measure too long");
    chk_phase_launch: assert property (go && cmd_code == CMD_MEAS_PHASE
        |=> phase_det_en_r && !adc_abs_mode_r && adc_source_r == SRC_PHASE ##0 s_launch)
        else $error("Bad phase launch");
    chk_adj_refuse: assert property (go && cmd_code == CMD_REG_ADJUST && ext_reg_select
        |=> !reg_adj_start_r && !busy_r) else $error("Adjust not refused");
    chk_cal_gate: assert property (go && cmd_code == CMD_CAP_CAL && manual_cal != '0
        |=> !cap_cal_start_r) else $error("Calibration not refused");
    chk_rssi_clear: assert property (new_reception || go && cmd_code == CMD_CLEAR_RSSI
        |=> rssi_clear_r) else $error("No signal strength clear");
    chk_result_hold: assert property ($changed(converter_result_r)
        |-> $past(adc_done) && converter_result_r == $past(adc_data))
        else $error("Result changed without conversion");
endmodule : meas_cmd_chk
bind meas_cmd_seq meas_cmd_chk #(.MCAL_W(MCAL_W)) meas_cmd_chk_inst (
    .clk_sys, .nrst, .cmd_valid, .cmd_code, .busy_r, .am_modulated_r, .adc_start_r,
    .adc_abs_mode_r, .adc_source_r, .amp_det_en_r, .phase_det_en_r, .tx_enable_r,
    .reg_adj_start_r, .ext_reg_select, .cap_cal_start_r, .manual_cal, .rssi_clear_r,
    .new_reception, .adc_done, .adc_data, .converter_result_r);
`default_nettype wire

//--- sim/tb.sv
// Bench for the command sequencer: a command table, then hand tests.
// Assumes the analog responder answers every start after dly cycles, except while mute is set.
`timescale 1ns/10ps
`default_nettype none
module tb
    import meas_cmd_pkg::*;
;
    typedef struct packed {
        logic [7:0] c;
        logic       e;
        logic [3:0] m;
        logic       r;
        logic [6:0] p;
        logic [7:0] res;
    } row_s;
    // Host issues capacitive calibration both in ready mode and out of it; capacitive measurement only out of it
    row_s rows [14] = '{
        '{CMD_MEAS_AMP, '0, '0, '0, 7'h01, 8'h30}, '{CMD_GAIN_RESET, '0, '0, '0, 7'h20, 8'h30},
        '{CMD_CLEAR_RSSI, '0, '0, '0, 7'h10, 8'h30}, '{CMD_REG_ADJUST, '0, '0, '0, 7'h08, 8'h30},
        '{CMD_REG_ADJUST, '1, '0, '0, 7'h00, 8'h30}, '{CMD_CAP_CAL, '0, '0, '1, 7'h04, 8'h30},
        '{CMD_CAP_CAL, '0, 4'h2, '1, 7'h00, 8'h30}, '{CMD_CAP_CAL, '0, '0, '0, 7'h04, 8'h30},
        '{CMD_CAP_MEAS, '0, '0, '0, 7'h02, 8'h30}, '{CMD_MEAS_PHASE, '0, '0, '0, 7'h01, 8'h40},
        '{CMD_MEAS_SUPPLY, '0, '0, '0, 7'h01, 8'h50}, '{8'h55, '0, '0, '0, 7'h00, 8'h50},
        '{CMD_AM_TOGGLE, '0, '0, '0, 7'h40, 8'h50}, '{CMD_AM_TOGGLE, '0, '0, '0, 7'h00, 8'h50}};
    // Code in upper nibble, watched bit in lower; 8 means an analog code
    logic [7:0] ot [7] = '{8'h10, 8'h21, 8'h52, 8'h63, 8'h74, 8'hB6, 8'h38};
    logic clk_sys, nrst, cmd_valid, serial_frame_select, reg_wr, reg_rd, tx_en_cfg, rx_en_cfg;
    logic ext_reg_select, ready_mode, new_reception, adc_done, reg_adj_done, cap_done;
    logic mute, tx_enable_r, rx_enable_r, am_modulated_r, adc_start_r;
    logic gain_reset_r, rssi_clear_r, reg_adj_start_r, cap_cal_start_r, cap_meas_start_r;
    logic cap_cal_irq_r, transparent_r, test_space_r, observation_pin_a_r;
    logic observation_pin_b_r, busy_r;
    logic [7:0] cmd_code, reg_wdata, adc_data, obs_digital, dly;
    logic [7:0] converter_result_r, test_rdata_r, obs_select_r;
    logic [5:0] reg_addr;
    logic [3:0] manual_cal;
    logic [2:0] supply_select, adc_supply_sel_r;
    logic [1:0] adc_source_r;
    int n_errors = 0;
    int checks = 0;
    int irq_cnt = 0;
    int irq_base;
    meas_cmd_seq #(.ADJ_CYC(50), .CAL_CYC(30), .CMEAS_CYC(25)) meas_cmd_seq_inst (
        .clk_sys, .nrst, .cmd_valid, .cmd_code, .serial_frame_select, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata, .tx_en_cfg, .rx_en_cfg, .ext_reg_select, .supply_select,
        .manual_cal, .ready_mode, .new_reception, .adc_done, .adc_data, .reg_adj_done,
        .cap_done, .obs_digital, .tx_enable_r, .rx_enable_r, .am_modulated_r,
        .amp_det_en_r(), .phase_det_en_r(), .adc_start_r, .adc_abs_mode_r(), .adc_source_r,
        .adc_supply_sel_r, .converter_result_r, .gain_reset_r, .rssi_clear_r,
        .reg_adj_start_r, .cap_cal_start_r, .cap_meas_start_r, .cap_cal_irq_r,
        .transparent_r, .test_space_r, .test_rdata_r, .obs_select_r, .observation_pin_a_r,
        .observation_pin_b_r, .busy_r);
    analog_resp analog_resp_inst (.clk_sys, .nrst, .adc_start_r, .adc_source_r,
        .reg_adj_start_r, .cap_cal_start_r, .cap_meas_start_r, .mute, .dly, .adc_done,
        .adc_data, .reg_adj_done, .cap_done);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Counted at the falling edge, where the one-cycle pulse has settled
    always @(negedge clk_sys) if (cap_cal_irq_r === 1'b1) irq_cnt <= irq_cnt + 1;
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic cmd(input logic [7:0] c);
        cmd_code = c;
        cmd_valid = 1'b1;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
    endtask : cmd
    task automatic wr(input logic [7:0] d);
        reg_addr = OBS_SEL_ADDR;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask : wr
    task automatic wait_idle;
        int k;
        k = 0;
        while (busy_r !== 1'b0 && k < 3000) begin
            @(negedge clk_sys);
            k++;
        end
        chk("idle", 8'h01, k < 3000);
    endtask : wait_idle
    task automatic end_sim;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        end_sim();
    end
    initial begin
        {cmd_valid, cmd_code, reg_wr, reg_rd, reg_addr, reg_wdata, tx_en_cfg, rx_en_cfg} = '0;
        {ext_reg_select, manual_cal, ready_mode, new_reception, obs_digital, mute} = '0;
        {serial_frame_select, supply_select, dly, nrst} = {1'b1, 3'h5, 8'h05, 1'b0};
        repeat (12) @(negedge clk_sys);
        chk("obs reset", OBS_SEL_RESET, obs_select_r);
        nrst = 1'b1;
        for (int n = 0; n < 14; n++) begin
            if (rows[n].c == CMD_REG_ADJUST) begin
                ext_reg_select = 1'b1;
                @(negedge clk_sys);
                ext_reg_select = 1'b0;
            end
            {ext_reg_select, manual_cal, ready_mode} = {rows[n].e, rows[n].m, rows[n].r};
            irq_base = irq_cnt;
            @(negedge clk_sys);
            cmd(rows[n].c);
            chk("pulses", {1'b0, rows[n].p}, {1'b0, am_modulated_r, gain_reset_r, rssi_clear_r,
                reg_adj_start_r, cap_cal_start_r, cap_meas_start_r, adc_start_r});
            wait_idle();
            repeat (3) @(negedge clk_sys);
            chk("irq", rows[n].r && rows[n].p[2], 8'(irq_cnt - irq_base));
            chk("result", rows[n].res, converter_result_r);
            chk("enables", 8'h00, {tx_enable_r, rx_enable_r});
        end
        chk("supply sel", 8'h05, adc_supply_sel_r);
        new_reception = 1'b1;
        @(negedge clk_sys);
        new_reception = 1'b0;
        chk("rssi new", 8'h01, rssi_clear_r);
        mute = 1'b1;
        cmd(CMD_MEAS_AMP);
        repeat (10) @(negedge clk_sys);
        cmd(CMD_GAIN_RESET);
        chk("busy refuse", 8'h00, gain_reset_r);
        wait_idle();
        chk("timeout hold", 8'h50, converter_result_r);
        {mute, dly} = {1'b0, 8'hC8};
        cmd(CMD_MEAS_AMP);
        wait_idle();
        chk("slow amp", 8'h30, converter_result_r);
        // Prior enables differ here, so the restore is visible
        {tx_en_cfg, ext_reg_select} = 2'b11;
        @(negedge clk_sys);
        ext_reg_select = 1'b0;
        cmd(CMD_REG_ADJUST);
        chk("adjust enables", 8'h03, {tx_enable_r, rx_enable_r});
        wait_idle();
        repeat (3) @(negedge clk_sys);
        chk("restored enables", 8'h02, {tx_enable_r, rx_enable_r});
        tx_en_cfg = 1'b0;
        dly = 8'h05;
        serial_frame_select = 1'b0;
        @(negedge clk_sys);
        cmd(CMD_TRANSPARENT);
        serial_frame_select = 1'b1;
        repeat (30) @(negedge clk_sys);
        chk("transparent on", 8'h01, transparent_r);
        serial_frame_select = 1'b0;
        repeat (6) @(negedge clk_sys);
        chk("transparent off", 8'h00, transparent_r);
        cmd(CMD_TEST_ACCESS);
        chk("test space", 8'h01, test_space_r);
        wr(8'h4B);
        {reg_rd, obs_digital} = {1'b1, 8'h20};
        @(negedge clk_sys);
        reg_rd = 1'b0;
        chk("test read", 8'h4B, test_rdata_r);
        repeat (2) @(negedge clk_sys);
        chk("pin a", 8'h01, observation_pin_a_r);
        // Six digital codes and one analog code, once measurements are over
        for (int j = 0; j < 7; j++) begin
            wr({4'h4, ot[j][7:4]});
            for (int ph = 0; ph < 2; ph++) begin
                obs_digital = 8'h01 << ot[j][3:0];
                if (ph == 1) obs_digital = ~obs_digital;
                repeat (3) @(negedge clk_sys);
                chk("pin b", (ph == 0) && (ot[j][3:0] < 4'h8), observation_pin_b_r);
            end
        end
        serial_frame_select = 1'b1;
        repeat (6) @(negedge clk_sys);
        chk("test space off", 8'h00, test_space_r);
        end_sim();
    end
endmodule : tb
`default_nettype wire
